// ===== core/cpu_regs_map.svh
// cpu_regs_map.svh: offsets, field positions and reset values of the
// core register set.
// assumes it is included by cpu_regs_pkg only, through its bare name.
`ifndef CPU_REGS_MAP_SVH
`define CPU_REGS_MAP_SVH
`define WORD_W 16
`define ADDR_W 20
`define FLAG_W 11
`define BANK_REGS 7
`define BUS_W 32
`define SEL_W 5
// register codes, also the word offsets on the software port
`define OFF_DATA_ZERO 5'h00
`define OFF_DATA_ONE 5'h01
`define OFF_DATA_TWO 5'h02
`define OFF_DATA_THREE 5'h03
`define OFF_ADDR_ZERO 5'h04
`define OFF_ADDR_ONE 5'h05
`define OFF_FRAME_BASE 5'h06
`define OFF_VECTOR_BASE 5'h07
`define OFF_INSTR_PTR 5'h08
`define OFF_USER_SP 5'h09
`define OFF_INT_SP 5'h0a
`define OFF_STATIC_BASE 5'h0b
`define OFF_FLAGS 5'h0c
`define OFF_ACTIVE_SP 5'h0d
`define OFF_PAIR_LOW 5'h0e
`define OFF_PAIR_HIGH 5'h0f
`define OFF_PAIR_ADDR 5'h10
// flag word field positions
`define FLAG_CARRY 0
`define FLAG_DEBUG 1
`define FLAG_ZERO 2
`define FLAG_SIGN 3
`define FLAG_BANK 4
`define FLAG_OVERFLOW 5
`define FLAG_INT_EN 6
`define FLAG_STACK_SEL 7
`define FLAG_PRIO_LO 8
`define FLAG_PRIO_HI 10
// highest software interrupt number that forces the interrupt stack
`define SW_INT_U_MAX 6'h1f
// reset values
`define RST_WORD 16'h0000
`define RST_ADDR 20'h00000
`define RST_FLAGS 11'h000
`endif

// ===== core/cpu_regs_pkg.sv
// cpu_regs_pkg: types shared by the register file modules.
// assumes cpu_regs_map.svh is on the include path.
package cpu_regs_pkg;
`include "cpu_regs_map.svh"

  typedef enum logic [`SEL_W-1:0] {
    SEL_DATA_ZERO   = `OFF_DATA_ZERO,
    SEL_DATA_ONE    = `OFF_DATA_ONE,
    SEL_DATA_TWO    = `OFF_DATA_TWO,
    SEL_DATA_THREE  = `OFF_DATA_THREE,
    SEL_ADDR_ZERO   = `OFF_ADDR_ZERO,
    SEL_ADDR_ONE    = `OFF_ADDR_ONE,
    SEL_FRAME_BASE  = `OFF_FRAME_BASE,
    SEL_VECTOR_BASE = `OFF_VECTOR_BASE,
    SEL_INSTR_PTR   = `OFF_INSTR_PTR,
    SEL_USER_SP     = `OFF_USER_SP,
    SEL_INT_SP      = `OFF_INT_SP,
    SEL_STATIC_BASE = `OFF_STATIC_BASE,
    SEL_FLAGS       = `OFF_FLAGS,
    SEL_ACTIVE_SP   = `OFF_ACTIVE_SP,
    SEL_PAIR_LOW    = `OFF_PAIR_LOW,
    SEL_PAIR_HIGH   = `OFF_PAIR_HIGH,
    SEL_PAIR_ADDR   = `OFF_PAIR_ADDR
  } reg_sel_e;

  typedef enum logic [1:0] {
    MODE_WORD      = 2'h0,
    MODE_LOW_BYTE  = 2'h1,
    MODE_HIGH_BYTE = 2'h2
  } access_mode_e;

  typedef struct packed {
    logic [`BANK_REGS-1:0][1:0]        lane;
    logic [`BANK_REGS-1:0][`WORD_W-1:0] data;
  } bank_wr_s;
endpackage

// ===== core/bank_if.sv
// bank_if: write lanes into one register bank and its contents back.
// assumes one instance per bank, driven by the register file top.
interface bank_if #(
  parameter int NREG = 7,
  parameter int W    = 16
);
  logic [NREG-1:0][1:0]   wrLane;
  logic [NREG-1:0][W-1:0] wrData;
  logic [NREG-1:0][W-1:0] rdData;
  modport store (input wrLane, input wrData, output rdData);
  modport user  (output wrLane, output wrData, input rdData);
endinterface

// ===== core/reg_bank.sv
// reg_bank: one bank of data, address and frame base registers.
// assumes byte lanes come already decoded through bank_if.
module reg_bank
  import cpu_regs_pkg::*;
#(
  parameter int NREG = `BANK_REGS,
  parameter int W    = `WORD_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  bank_if.store    port
);
  if (NREG != `BANK_REGS || W != `WORD_W) begin : g_chk
    $error("reg_bank: unsupported geometry");
  end

  logic [W-1:0] cells [NREG];

  // contents change only on their own lanes, never by a bank switch
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NREG; i++) cells[i] <= `RST_WORD;
    end else if (ce) begin
      for (int i = 0; i < NREG; i++) begin
        if (port.wrLane[i][0]) cells[i][7:0] <= port.wrData[i][7:0];
        if (port.wrLane[i][1]) cells[i][15:8] <= port.wrData[i][15:8];
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NREG; i++) port.rdData[i] = cells[i];
  end
endmodule // reg_bank

// ===== core/flag_unit.sv
// flag_unit: the processor flag word and the interrupt gate.
// assumes every input comes from logic on the same clock.
module flag_unit
  import cpu_regs_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                ce,
  input  wire logic                wrFlags,
  input  wire logic [`FLAG_W-1:0]  wrData,
  input  wire logic                aluUpdate,
  input  wire logic [3:0]          aluMask,
  input  wire logic                aluByte,
  input  wire logic [`WORD_W-1:0]  aluResult,
  input  wire logic                aluCarry,
  input  wire logic                aluOverflow,
  input  wire logic                hwAccept,
  input  wire logic                swIntExec,
  input  wire logic [5:0]          swIntNum,
  input  wire logic                reqValid,
  input  wire logic [2:0]          reqPriority,
  output logic      [`FLAG_W-1:0]  flags,
  output logic                     irqAllowed
);
  logic resZero;
  logic resSign;

  assign resZero = aluByte ? (aluResult[7:0] == 8'h00)
                           : (aluResult == 16'h0000);
  assign resSign = aluByte ? aluResult[7] : aluResult[15];

  // a later assignment wins: alu, then flag writes, then acceptance
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flags <= `RST_FLAGS;
    end else if (ce) begin
      if (aluUpdate) begin
        if (aluMask[0]) flags[`FLAG_CARRY] <= aluCarry;
        if (aluMask[1]) flags[`FLAG_ZERO] <= resZero;
        if (aluMask[2]) flags[`FLAG_SIGN] <= resSign;
        if (aluMask[3]) flags[`FLAG_OVERFLOW] <= aluOverflow;
      end
      if (wrFlags) flags <= wrData;
      if (hwAccept || swIntExec) flags[`FLAG_INT_EN] <= 1'b0;
      if (hwAccept || (swIntExec && swIntNum <= `SW_INT_U_MAX)) begin
        flags[`FLAG_STACK_SEL] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irqAllowed <= 1'b0;
    end else if (ce) begin
      irqAllowed <= reqValid && flags[`FLAG_INT_EN]
        && (reqPriority > flags[`FLAG_PRIO_HI:`FLAG_PRIO_LO]);
    end
  end
endmodule // flag_unit

// ===== core/cpu_register_file.sv
// cpu_register_file: architectural register set of a 16-bit core.
// assumes the datapath, the interrupt logic and the software port all
// run on clk; no input needs synchronising.
//
// Local design decisions: the register addresses and the address-and-strobe port.
module cpu_register_file
  import cpu_regs_pkg::*;
#(
  parameter int NREG = `BANK_REGS
) (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                ce,
  input  wire logic [`SEL_W-1:0]   regAddr,
  input  wire logic [`BUS_W-1:0]   regWrData,
  input  wire logic                regWrite,
  input  wire logic                regRead,
  output logic      [`BUS_W-1:0]   regRdData,
  input  wire logic                dpWrite,
  input  wire reg_sel_e            dpWrSel,
  input  wire access_mode_e        dpWrMode,
  input  wire logic [`BUS_W-1:0]   dpWrData,
  input  wire logic                dpRead,
  input  wire reg_sel_e            dpRdSel,
  input  wire access_mode_e        dpRdMode,
  output logic      [`BUS_W-1:0]   dpRdData,
  input  wire logic                aluUpdate,
  input  wire logic [3:0]          aluMask,
  input  wire logic                aluByte,
  input  wire logic [`WORD_W-1:0]  aluResult,
  input  wire logic                aluCarry,
  input  wire logic                aluOverflow,
  input  wire logic                pcAdvance,
  input  wire logic [2:0]          pcStep,
  input  wire logic                spAdjust,
  input  wire logic [7:0]          spDelta,
  input  wire logic                hwAccept,
  input  wire logic                swIntExec,
  input  wire logic [5:0]          swIntNum,
  input  wire logic                reqValid,
  input  wire logic [2:0]          reqPriority,
  output logic                     irqAllowed,
  output logic      [`FLAG_W-1:0]  flagsWord,
  output logic      [`ADDR_W-1:0]  pcValue,
  output logic      [`ADDR_W-1:0]  vectorBase,
  output logic      [`WORD_W-1:0]  activeSp
);
  if (NREG != `BANK_REGS) begin : g_chk
    $error("cpu_register_file: bank must hold seven registers");
  end

  // ------------------------------------------------------------
  // state outside the banks
  // ------------------------------------------------------------
  logic [`WORD_W-1:0] userSp;
  logic [`WORD_W-1:0] intSp;
  logic [`WORD_W-1:0] staticBase;
  logic [`FLAG_W-1:0] flags;

  // ------------------------------------------------------------
  // bank storage
  // ------------------------------------------------------------
  bank_if #(.NREG(NREG), .W(`WORD_W)) bankZero ();
  bank_if #(.NREG(NREG), .W(`WORD_W)) bankOne ();

  reg_bank #(.NREG(NREG), .W(`WORD_W)) u_bank_zero (
    .clk   (clk),
    .reset (reset),
    .ce    (ce),
    .port  (bankZero.store)
  );

  reg_bank #(.NREG(NREG), .W(`WORD_W)) u_bank_one (
    .clk   (clk),
    .reset (reset),
    .ce    (ce),
    .port  (bankOne.store)
  );

  logic                              bankSel;
  logic [`BANK_REGS-1:0][`WORD_W-1:0] activeBank;

  assign bankSel = flags[`FLAG_BANK];
  assign activeBank = bankSel ? bankOne.rdData
                              : bankZero.rdData;

  // ------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------
  // turns one access into byte lanes of the seven banked registers
  function automatic bank_wr_s bank_decode(
    input logic         en,
    input reg_sel_e     sel,
    input access_mode_e mode,
    input logic [31:0]  d
  );
    bank_wr_s w;
    logic [2:0] idx;
    w = '0;
    idx = sel[2:0];
    if (en) begin
      case (sel)
        SEL_PAIR_LOW: begin
          w.lane[0] = 2'h3;
          w.data[0] = d[15:0];
          w.lane[2] = 2'h3;
          w.data[2] = d[31:16];
        end
        SEL_PAIR_HIGH: begin
          w.lane[1] = 2'h3;
          w.data[1] = d[15:0];
          w.lane[3] = 2'h3;
          w.data[3] = d[31:16];
        end
        SEL_PAIR_ADDR: begin
          w.lane[4] = 2'h3;
          w.data[4] = d[15:0];
          w.lane[5] = 2'h3;
          w.data[5] = d[31:16];
        end
        SEL_DATA_ZERO, SEL_DATA_ONE: begin
          case (mode)
            MODE_LOW_BYTE: begin
              w.lane[idx] = 2'h1;
              w.data[idx] = {8'h00, d[7:0]};
            end
            MODE_HIGH_BYTE: begin
              w.lane[idx] = 2'h2;
              w.data[idx] = {d[7:0], 8'h00};
            end
            default: begin
              w.lane[idx] = 2'h3;
              w.data[idx] = d[15:0];
            end
          endcase
        end
        SEL_DATA_TWO, SEL_DATA_THREE, SEL_ADDR_ZERO,
        SEL_ADDR_ONE, SEL_FRAME_BASE: begin
          w.lane[idx] = 2'h3;
          w.data[idx] = d[15:0];
        end
        default: w = '0;
      endcase
    end
    return w;
  endfunction

  bank_wr_s swBank;
  bank_wr_s dpBank;
  bank_wr_s mergedBank;

  assign swBank = bank_decode(regWrite, reg_sel_e'(regAddr),
                              MODE_WORD, regWrData);
  assign dpBank = bank_decode(dpWrite, dpWrSel, dpWrMode, dpWrData);

  // the datapath wins a byte that both sides write in one cycle
  always_comb begin
    for (int i = 0; i < `BANK_REGS; i++) begin
      mergedBank.lane[i] = swBank.lane[i] | dpBank.lane[i];
      for (int b = 0; b < 2; b++) begin
        mergedBank.data[i][b*8 +: 8] = dpBank.lane[i][b]
          ? dpBank.data[i][b*8 +: 8] : swBank.data[i][b*8 +: 8];
      end
    end
  end

  // only the selected bank sees lanes; the other keeps its contents
  assign bankZero.wrLane = bankSel ? '0 : mergedBank.lane;
  assign bankOne.wrLane  = bankSel ? mergedBank.lane : '0;
  assign bankZero.wrData = mergedBank.data;
  assign bankOne.wrData  = mergedBank.data;

  // strobes for the unbanked registers
  function automatic logic hit(
    input logic     swEn,
    input logic     dpEn,
    input reg_sel_e dpSel,
    input reg_sel_e target
  );
    return (swEn && regAddr == target) || (dpEn && dpSel == target);
  endfunction

  // one shared value: a datapath write lends its data to a software one
  logic [`BUS_W-1:0] wrValue;

  assign wrValue = dpWrite ? dpWrData : regWrData;

  // ------------------------------------------------------------
  // vector table base and instruction pointer
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      vectorBase <= `RST_ADDR;
    end else if (ce) begin
      if (hit(regWrite, dpWrite, dpWrSel, SEL_VECTOR_BASE)) begin
        vectorBase <= wrValue[`ADDR_W-1:0];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pcValue <= `RST_ADDR;
    end else if (ce) begin
      if (hit(regWrite, dpWrite, dpWrSel, SEL_INSTR_PTR)) begin
        pcValue <= wrValue[`ADDR_W-1:0];
      end else if (pcAdvance) begin
        pcValue <= `ADDR_W'(pcValue + `ADDR_W'(pcStep));
      end
    end
  end

  // ------------------------------------------------------------
  // stack pointers
  // ------------------------------------------------------------
  logic stackSel;
  logic userSpWr;
  logic intSpWr;
  logic activeWr;

  assign stackSel = flags[`FLAG_STACK_SEL];
  assign activeWr = hit(regWrite, dpWrite, dpWrSel, SEL_ACTIVE_SP);
  assign userSpWr = hit(regWrite, dpWrite, dpWrSel, SEL_USER_SP)
                    || (activeWr && stackSel);
  assign intSpWr  = hit(regWrite, dpWrite, dpWrSel, SEL_INT_SP)
                    || (activeWr && !stackSel);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      userSp <= `RST_WORD;
      intSp  <= `RST_WORD;
    end else if (ce) begin
      if (userSpWr) begin
        userSp <= wrValue[`WORD_W-1:0];
      end else if (spAdjust && stackSel) begin
        userSp <= `WORD_W'(userSp + {{8{spDelta[7]}}, spDelta});
      end
      if (intSpWr) begin
        intSp <= wrValue[`WORD_W-1:0];
      end else if (spAdjust && !stackSel) begin
        intSp <= `WORD_W'(intSp + {{8{spDelta[7]}}, spDelta});
      end
    end
  end

  // follows the selected pointer one cycle behind
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      activeSp <= `RST_WORD;
    end else if (ce) begin
      activeSp <= stackSel ? userSp : intSp;
    end
  end

  // ------------------------------------------------------------
  // static base
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      staticBase <= `RST_WORD;
    end else if (ce) begin
      if (hit(regWrite, dpWrite, dpWrSel, SEL_STATIC_BASE)) begin
        staticBase <= wrValue[`WORD_W-1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // flag word
  // ------------------------------------------------------------
  logic flagsWr;

  assign flagsWr = hit(regWrite, dpWrite, dpWrSel, SEL_FLAGS);

  flag_unit u_flags (
    .clk         (clk),
    .reset       (reset),
    .ce          (ce),
    .wrFlags     (flagsWr),
    .wrData      (wrValue[`FLAG_W-1:0]),
    .aluUpdate   (aluUpdate),
    .aluMask     (aluMask),
    .aluByte     (aluByte),
    .aluResult   (aluResult),
    .aluCarry    (aluCarry),
    .aluOverflow (aluOverflow),
    .hwAccept    (hwAccept),
    .swIntExec   (swIntExec),
    .swIntNum    (swIntNum),
    .reqValid    (reqValid),
    .reqPriority (reqPriority),
    .flags       (flags),
    .irqAllowed  (irqAllowed)
  );

  assign flagsWord = flags;

  // ------------------------------------------------------------
  // read paths
  // ------------------------------------------------------------
  function automatic logic [31:0] read_value(
    input reg_sel_e     sel,
    input access_mode_e mode
  );
    logic [`WORD_W-1:0] w;
    logic [31:0]        v;
    w = activeBank[sel[2:0]];
    v = '0;
    case (sel)
      SEL_DATA_ZERO, SEL_DATA_ONE: begin
        case (mode)
          MODE_LOW_BYTE:  v = {24'h000000, w[7:0]};
          MODE_HIGH_BYTE: v = {24'h000000, w[15:8]};
          default:        v = {16'h0000, w};
        endcase
      end
      SEL_DATA_TWO, SEL_DATA_THREE, SEL_ADDR_ZERO,
      SEL_ADDR_ONE, SEL_FRAME_BASE: v = {16'h0000, w};
      SEL_PAIR_LOW:    v = {activeBank[2], activeBank[0]};
      SEL_PAIR_HIGH:   v = {activeBank[3], activeBank[1]};
      SEL_PAIR_ADDR:   v = {activeBank[5], activeBank[4]};
      SEL_VECTOR_BASE: v = 32'(vectorBase);
      SEL_INSTR_PTR:   v = 32'(pcValue);
      SEL_USER_SP:     v = {16'h0000, userSp};
      SEL_INT_SP:      v = {16'h0000, intSp};
      SEL_ACTIVE_SP:   v = {16'h0000, stackSel ? userSp : intSp};
      SEL_STATIC_BASE: v = {16'h0000, staticBase};
      // bits above the flag word read as zero
      SEL_FLAGS:       v = 32'(flags);
      default:         v = '0;
    endcase
    return v;
  endfunction

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      regRdData <= '0;
    end else if (ce) begin
      regRdData <= regRead
        ? read_value(reg_sel_e'(regAddr), MODE_WORD) : '0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dpRdData <= '0;
    end else if (ce && dpRead) begin
      dpRdData <= read_value(dpRdSel, dpRdMode);
    end
  end
endmodule // cpu_register_file

// ===== tb/cpu_register_file_chk.sv
// cpu_register_file_chk: flag word and interrupt gate assertions.
// assumes it is bound onto cpu_register_file and sees its ports only.
module cpu_register_file_chk (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        ce,
  input wire logic        regWrite,
  input wire logic        dpWrite,
  input wire logic        aluUpdate,
  input wire logic [3:0]  aluMask,
  input wire logic        aluByte,
  input wire logic [15:0] aluResult,
  input wire logic        aluCarry,
  input wire logic        aluOverflow,
  input wire logic        hwAccept,
  input wire logic        swIntExec,
  input wire logic [5:0]  swIntNum,
  input wire logic        reqValid,
  input wire logic [2:0]  reqPriority,
  input wire logic        irqAllowed,
  input wire logic [10:0] flagsWord
);
  // --------------------------------------------------------------
  // expected zero and sign of the last alu result
  // --------------------------------------------------------------
  logic zExp, sExp;
  always_ff @(posedge clk) begin
    zExp <= aluByte ? aluResult[7:0] == 8'h00 : aluResult == 16'h0000;
    sExp <= aluByte ? aluResult[7] : aluResult[15];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // alu update with no software or datapath register write in the same cycle
  sequence s_alu(int b);
    ce && aluUpdate && aluMask[b] && !regWrite && !dpWrite;
  endsequence
  property p_carry; s_alu(0) |=> flagsWord[0] == $past(aluCarry);
  endproperty
  property p_zero; s_alu(1) |=> flagsWord[2] == zExp; endproperty
  property p_sign; s_alu(2) |=> flagsWord[3] == sExp; endproperty
  property p_ovf; s_alu(3) |=> flagsWord[5] == $past(aluOverflow);
  endproperty
  property p_ie; ce && hwAccept |=> !flagsWord[6]; endproperty
  property p_ss;
    ce && (hwAccept || swIntExec && swIntNum <= 6'h1f) |=> !flagsWord[7];
  endproperty
  property p_mask; ce && !flagsWord[6] |=> !irqAllowed; endproperty
  property p_ipl; ce && reqPriority <= flagsWord[10:8] |=> !irqAllowed;
  endproperty
  property p_allow;
    ce && reqValid && flagsWord[6] && reqPriority > flagsWord[10:8]
      |=> irqAllowed;
  endproperty
  a_carry: assert property (p_carry) else $error("carry wrong");
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  a_sign: assert property (p_sign) else $error("sign flag wrong");
  a_ovf: assert property (p_ovf) else $error("overflow flag wrong");
  a_ie: assert property (p_ie) else $error("enable not cleared");
  a_ss: assert property (p_ss) else $error("stack select kept");
  a_mask: assert property (p_mask) else $error("masked irq passed");
  a_ipl: assert property (p_ipl) else $error("low priority passed");
  a_allow: assert property (p_allow) else $error("irq not allowed");
endmodule // cpu_register_file_chk

bind cpu_register_file cpu_register_file_chk chk_inst (
  .clk, .reset, .ce, .regWrite, .dpWrite, .aluUpdate, .aluMask, .aluByte,
  .aluResult, .aluCarry, .aluOverflow, .hwAccept, .swIntExec, .swIntNum,
  .reqValid, .reqPriority, .irqAllowed, .flagsWord
);

// ===== tb/tb_top.sv
// tb_top: self-checking bench for the core register file.
// assumes cpu_regs_pkg and the core sources are compiled before it.
`define CHK(n, e, g) begin checksDone++; if ((g) !== (e)) begin \
  numErrors++; $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_top
  import cpu_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk, reset, ce, regWrite, regRead, dpWrite, dpRead;
  logic         aluUpdate, aluByte, aluCarry, aluOverflow, pcAdvance;
  logic         spAdjust, hwAccept, swIntExec, reqValid, irqAllowed;
  logic [4:0]   regAddr;
  logic [31:0]  regWrData, regRdData, dpWrData, dpRdData, q, v, seed;
  logic [3:0]   aluMask;
  logic [15:0]  aluResult, activeSp;
  logic [2:0]   pcStep, reqPriority;
  logic [7:0]   spDelta;
  logic [5:0]   swIntNum;
  logic [10:0]  flagsWord;
  logic [19:0]  pcValue, vectorBase;
  reg_sel_e     dpWrSel, dpRdSel;
  access_mode_e dpWrMode, dpRdMode;
  int           numErrors, checksDone, m[2][13];
  int           lo[3] = '{0, 1, 4};
  int           hi[3] = '{2, 3, 5};

  cpu_register_file cpu_register_file_inst (
    .clk, .reset, .ce, .regAddr, .regWrData, .regWrite, .regRead,
    .regRdData, .dpWrite, .dpWrSel, .dpWrMode, .dpWrData, .dpRead,
    .dpRdSel, .dpRdMode, .dpRdData, .aluUpdate, .aluMask, .aluByte,
    .aluResult, .aluCarry, .aluOverflow, .pcAdvance, .pcStep, .spAdjust,
    .spDelta, .hwAccept, .swIntExec, .swIntNum, .reqValid, .reqPriority,
    .irqAllowed, .flagsWord, .pcValue, .vectorBase, .activeSp
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // --------------------------------------------------------------
  // model and bus tasks
  // --------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int bk();
    return m[0][12][4];
  endfunction
  function automatic void mput(int a, logic [31:0] d);
    if (a == 13) a = m[0][12][7] ? 9 : 10;
    d &= (a == 7 || a == 8) ? 'hfffff : (a == 12) ? 'h7ff : 'hffff;
    if (a < 7) m[bk()][a] = d;
    else m[0][a] = d;
  endfunction
  function automatic int ex(int a);
    if (a > 13 && a < 17) return ex(hi[a-14]) << 16 | ex(lo[a-14]);
    if (a == 13) a = m[0][12][7] ? 9 : 10;
    if (a > 13) return 0;
    return a < 7 ? m[bk()][a] : m[0][a];
  endfunction
  task automatic wrc(int a, logic [31:0] d);
    @(posedge clk);
    regAddr   <= a[4:0];
    regWrData <= d;
    regWrite  <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    if (a > 13 && a < 17) begin
      mput(lo[a-14], {16'h0, d[15:0]});
      mput(hi[a-14], {16'h0, d[31:16]});
    end else if (a < 14) mput(a, d);
  endtask
  task automatic rc(int a);
    @(posedge clk);
    regAddr <= a[4:0];
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 q = regRdData;
    `CHK("regRdData", ex(a), q)
  endtask
  task automatic alu(logic [3:0] k, logic [15:0] r, logic b);
    @(posedge clk);
    {aluUpdate, aluMask, aluResult, aluByte} <= {1'b1, k, r, b};
    {aluCarry, aluOverflow} <= {r[1], r[2]};
    @(posedge clk);
    aluUpdate <= 1'b0;
    if (k[0]) m[0][12][0] = r[1];
    if (k[1]) m[0][12][2] = b ? r[7:0] == 8'h00 : r == 16'h0000;
    if (k[2]) m[0][12][3] = b ? r[7] : r[15];
    if (k[3]) m[0][12][5] = r[2];
    rc(12);
    `CHK("flagsWord", m[0][12], {21'h0, flagsWord})
  endtask
  task automatic acc(logic h, logic [5:0] n);
    wrc(12, 'hc0);
    @(posedge clk);
    {hwAccept, swIntExec, swIntNum} <= {h, !h, n};
    @(posedge clk);
    {hwAccept, swIntExec} <= 2'b00;
    m[0][12][6] = 0;
    if (h || n < 6'h20) m[0][12][7] = 0;
    rc(12);
  endtask
  task automatic completeRun();
    if (numErrors == 0 && checksDone > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  initial begin
    {regWrite, regRead, dpWrite, dpRead, aluUpdate, aluByte} = '0;
    {aluCarry, aluOverflow, pcAdvance, spAdjust, hwAccept} = '0;
    {swIntExec, reqValid, regAddr, regWrData, dpWrData} = '0;
    {aluMask, aluResult, pcStep, reqPriority, spDelta, swIntNum} = '0;
    dpWrSel = SEL_DATA_ZERO;
    dpRdSel = SEL_DATA_ZERO;
    dpWrMode = MODE_WORD;
    dpRdMode = MODE_WORD;
    ce = 1'b1;
    reset = 1'b1;
    seed = 32'h4a9c;
    m = '{default: 0};
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    for (int a = 0; a < 13; a++) rc(a);
    for (int b = 0; b < 2; b++) begin
      wrc(12, b << 4);
      for (int a = 0; a < 12; a++) wrc(a, rnd());
    end
    for (int b = 0; b < 2; b++) begin
      wrc(12, b << 4);
      for (int a = 0; a < 13; a++) rc(a);
      `CHK("vectorBase", ex(7), {12'h0, vectorBase})
      `CHK("pcValue", ex(8), {12'h0, pcValue})
      for (int a = 14; a < 17; a++) begin
        wrc(a, rnd());
        rc(a);
        rc(lo[a-14]);
      end
    end
    for (int u = 1; u >= 0; u--) begin
      wrc(12, u << 7);
      wrc(13, rnd());
      v = rnd();
      @(posedge clk);
      {pcAdvance, spAdjust, pcStep, spDelta} <= {2'b11, v[10:0]};
      @(posedge clk);
      {pcAdvance, spAdjust} <= 2'b00;
      mput(8, ex(8) + v[10:8]);
      mput(13, ex(13) + {{24{v[7]}}, v[7:0]});
      rc(8);
      `CHK("pcValue", ex(8), {12'h0, pcValue})
      rc(9 + (1 - u));
      `CHK("activeSp", ex(13), {16'h0, activeSp})
    end
    wrc(17, rnd());
    rc(17);
    for (int s = 0; s < 4; s++) begin
      v = rnd();
      @(posedge clk);
      dpWrite  <= 1'b1;
      dpWrSel  <= s[0] ? SEL_DATA_ONE : SEL_DATA_ZERO;
      dpRdSel  <= s[0] ? SEL_DATA_ONE : SEL_DATA_ZERO;
      dpWrMode <= s[1] ? MODE_LOW_BYTE : MODE_HIGH_BYTE;
      dpRdMode <= s[1] ? MODE_LOW_BYTE : MODE_HIGH_BYTE;
      dpWrData <= v;
      @(posedge clk);
      dpWrite <= 1'b0;
      dpRead  <= 1'b1;
      @(posedge clk);
      dpRead <= 1'b0;
      if (s[1]) m[bk()][s[0]][7:0] = v[7:0];
      else m[bk()][s[0]][15:8] = v[7:0];
      #1 `CHK("dpRdData", {24'h0, v[7:0]}, dpRdData)
      rc(s[0]);
    end
    for (int i = 0; i < 16; i++) begin
      v = rnd();
      alu(i[3:0], i % 3 ? v[15:0] : 16'h0000, i[2]);
    end
    alu(4'hf, 16'hff00, 1'b1);
    acc(1'b1, 6'h00);
    acc(1'b0, 6'h1f);
    acc(1'b0, 6'h20);
    for (int p = 0; p < 9; p++) begin
      wrc(12, p == 8 ? 'h300 : 'h340);
      reqValid    <= 1'b1;
      reqPriority <= p == 8 ? 3'h7 : p[2:0];
      repeat (2) @(posedge clk);
      #1 `CHK("irqAllowed", p > 3 && p < 8, irqAllowed)
    end
    completeRun();
  end

  initial begin
    #100us;
    numErrors++;
    completeRun();
  end
endmodule // tb_top
